// ==== hdl/touch_key_detect_filter.sv ====
// twelve-channel touch-key detection, calibration, filtering, key selection and beep, as an AHB-Lite slave
// assumes MEAS_IMP and SENSOR_CLK come from outside the clock domain; one AHB master, single word transfers
// What this block does, and what the host must keep
// RULE1 - touch only when impedance exceeds reference by more than touch variance
// RULE2 - one touch variance per channel, one shared environment variance
// RULE3 - host keeps touch variance about four to ten, above environment variance
// RULE4 - host keeps environment variance about one to five, below touch variances
// RULE5 - power-up calibration runs for 150 sensor clock periods
// RULE6 - touch at power-up defers calibration: two intervals after release, then 150
// RULE7 - above reference plus touch variance: touch, reference kept
// RULE8 - between environment and touch band: no touch, reference kept
// RULE9 - small rise within environment variance: reference follows the impedance
// RULE10 - impedance below reference: reference replaced by measurement
// RULE11 - recalibrate only after all channels quiet for the wait time
// RULE12 - while quiet, recalibrate once per calibration interval
// RULE13 - count instant touches over integration period, readable as strength
// RULE14 - valid touch only when strength exceeds strength threshold
// RULE15 - optional second filter stage with period and threshold
// RULE16 - mode one passes only the strongest touched channel
// RULE17 - mode two passes every touched channel above threshold
// RULE18 - mode three passes the two strongest touched channels
// RULE19 - mode from feature register; final result in touch result register
// RULE20 - beep tone 1.5 to 400 kHz, length 100 us to 2.5 s
// RULE21 - general interrupt holds while unmasked events pend until cleared
// RULE22 - touch interrupt rises on touch event, drops on result read
// RULE23 - programmable reference delay code drives the measurement offset
// RULE24 - mask register gates sources onto the general interrupt
// RULE25 - writing the clear register clears pending status bits
// RULE26 - result has one bit per channel over low and high byte
// RULE27 - engine advances on sensor clock; references invalid after reset
`default_nettype none
module touch_key_detect_filter
   import touch_key_pkg::*;
#(
   parameter int FINE_TICK_CYCLES = BEEP_FINE_CYC
)
(
   input wire logic CLK,
   input wire logic RESETN,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic SENSOR_CLK,
   input wire logic [NCH*8-1:0] MEAS_IMP,
   output logic [7:0] REF_DELAY_CODE,
   output logic GENERAL_IRQ,
   output logic TOUCH_IRQ,
   output logic BEEP_OUT
);
   typedef struct packed {
      logic [2:0] sclk_sync;
      logic [NCH-1:0][7:0] imp_meta;
      logic [NCH-1:0][7:0] imp;
      logic [7:0] feature, evr, etc_wait, ref_delay, integ, int_mask;
      logic [7:0] beep_per, beep_freq, cal_int, filt_per, filt_thr;
      logic [NCH-1:0][7:0] tvr, thr, acc, strength, filt_cnt;
      logic dp_active, dp_write, rd_mem;
      logic [7:0] dp_idx;
      logic [31:0] rdata;
      eng_type eng;
      logic [3:0] ch;
      logic [NCH-1:0] valid, inst, filtered;
      logic sweep_touch, recal;
      cal_type cal;
      logic [7:0] cal_cnt, ival_cnt, integ_cnt, filt_win;
      logic [15:0] quiet;
      logic [15:0] result;
      logic [1:0] pend;
      logic tint;
      logic beeping, beep_out, beep_coarse;
      logic [7:0] tone_pre, tone_div, coarse_cnt;
      logic [14:0] fine_cnt;
      logic [6:0] dur_left;
   } state_type;

   state_type s, n;
   ref_store_if mem ();
   logic tick, accept, rd_touch, clr, beep_start, eval_hit, last, win_end, fine_end, unit_end;
   logic [7:0] aidx, eval_imp, wv;
   logic [1:0] ev;
   logic [NCH-1:0] vt, sel;
   logic [NCH-1:0][7:0] a_new;

   ref_store ref_store_i (.CLK(CLK), .port(mem.store));

   // true when a exceeds b by more than v, carried to nine bits
   function automatic logic above_by(input logic [7:0] a, input logic [7:0] b, input logic [7:0] v);
      return {1'b0, a} > ({1'b0, b} + {1'b0, v});
   endfunction : above_by

   // in range [base, base+NCH)
   function automatic logic in_bank(input logic [7:0] idx, input logic [7:0] base);
      return (idx >= base) && (idx < base + 8'(NCH));
   endfunction : in_bank

   // key selection over candidate channels
   function automatic logic [NCH-1:0] pick(input logic [1:0] mode, input logic [NCH-1:0] cand,
                                           input logic [NCH-1:0][7:0] str);
      logic f1, f2;
      logic [7:0] m1, m2;
      logic [3:0] i1, i2;
      logic [NCH-1:0] r;
      f1 = 1'b0;
      f2 = 1'b0;
      m1 = 8'h00;
      m2 = 8'h00;
      i1 = 4'h0;
      i2 = 4'h0;
      r = '0;
      for (int i = 0; i < NCH; i++)
         if (cand[i] && (!f1 || str[i] > m1))
         begin
            f1 = 1'b1;
            m1 = str[i];
            i1 = 4'(i);
         end
      for (int i = 0; i < NCH; i++)
         if (cand[i] && 4'(i) != i1 && (!f2 || str[i] > m2))
         begin
            f2 = 1'b1;
            m2 = str[i];
            i2 = 4'(i);
         end
      case (mode)
         2'h1: r[i1] = f1; // RULE16
         2'h3:
         begin
            r[i1] = f1; // RULE18
            r[i2] = f2;
         end
         default: r = cand; // RULE17 (mode zero behaves as two)
      endcase
      return r;
   endfunction : pick

   // register read mux, taken from the state after this cycle's write
   function automatic logic [7:0] read_reg(input state_type r, input logic [7:0] idx);
      if (in_bank(idx, IDX_TVR0)) return r.tvr[4'(idx - IDX_TVR0)];
      if (in_bank(idx, IDX_STR_THR0)) return r.thr[4'(idx - IDX_STR_THR0)];
      if (in_bank(idx, IDX_STRENGTH0)) return r.strength[4'(idx - IDX_STRENGTH0)]; // RULE13
      if (in_bank(idx, IDX_IMP0)) return r.imp[4'(idx - IDX_IMP0)];
      case (idx)
         IDX_FEATURE: return r.feature;
         IDX_EVR: return r.evr;
         IDX_ETC_WAIT: return r.etc_wait;
         IDX_REF_DELAY: return r.ref_delay;
         IDX_INTEG: return r.integ;
         IDX_INT_MASK: return r.int_mask;
         IDX_BEEP_PER: return r.beep_per;
         IDX_BEEP_FREQ: return r.beep_freq;
         IDX_CAL_INT: return r.cal_int;
         IDX_FILT_PER: return r.filt_per;
         IDX_FILT_THR: return r.filt_thr;
         IDX_STA: return {5'h00, r.beeping, r.cal};
         IDX_TOUCH_L: return r.result[7:0]; // RULE26
         IDX_TOUCH_H: return r.result[15:8];
         IDX_INT_PEND: return {6'h00, r.pend};
         default: return 8'h00;
      endcase
   endfunction : read_reg

   // whole next state in one place
   always_comb
   begin
      n = s;
      ev = 2'h0;
      vt = '0;
      sel = '0;
      a_new = '0;
      last = 1'b0;
      win_end = 1'b0;
      eval_hit = 1'b0;
      eval_imp = s.imp[s.ch];
      mem.wr_en = 1'b0;
      mem.wr_addr = s.ch;
      mem.wr_data = eval_imp;
      mem.ra_addr = s.ch;
      // third sync stage only feeds the edge detector
      n.sclk_sync = {s.sclk_sync[1], s.sclk_sync[0], SENSOR_CLK};
      tick = s.sclk_sync[1] & ~s.sclk_sync[2]; // RULE27
      n.imp_meta = MEAS_IMP;
      n.imp = s.imp_meta;

      // data phase writes
      wv = HWDATA[7:0];
      clr = 1'b0;
      beep_start = 1'b0;
      if (s.dp_active && s.dp_write)
      begin
         if (in_bank(s.dp_idx, IDX_TVR0)) n.tvr[4'(s.dp_idx - IDX_TVR0)] = wv; // RULE2
         if (in_bank(s.dp_idx, IDX_STR_THR0)) n.thr[4'(s.dp_idx - IDX_STR_THR0)] = wv;
         case (s.dp_idx)
            IDX_FEATURE: n.feature = wv; // RULE19
            IDX_EVR: n.evr = wv; // RULE2
            IDX_ETC_WAIT: n.etc_wait = wv;
            IDX_REF_DELAY: n.ref_delay = wv;
            IDX_INTEG: n.integ = wv;
            IDX_INT_MASK: n.int_mask = wv;
            IDX_INT_CLR: clr = 1'b1; // RULE25
            IDX_BEEP_PER:
            begin
               n.beep_per = wv;
               beep_start = |wv[6:0];
            end
            IDX_BEEP_FREQ: n.beep_freq = wv;
            IDX_CAL_INT: n.cal_int = wv;
            IDX_FILT_PER: n.filt_per = wv;
            IDX_FILT_THR: n.filt_thr = wv;
            default: ;
         endcase
      end

      // per-channel sweep, one sensor tick at a time; a tick during a sweep is dropped
      case (s.eng)
         ENG_IDLE:
         begin
            n.ch = 4'h0;
            n.sweep_touch = 1'b0;
            if (tick) n.eng = ENG_READ;
         end
         ENG_READ: n.eng = ENG_EVAL;
         ENG_EVAL:
         begin
            eval_hit = s.valid[s.ch] && above_by(eval_imp, mem.ra_data, s.tvr[s.ch]); // RULE1
            n.inst[s.ch] = eval_hit;
            if (eval_hit) n.sweep_touch = 1'b1;
            if (!s.valid[s.ch])
            begin
               mem.wr_en = 1'b1; // RULE27
               n.valid[s.ch] = 1'b1;
            end
            else if (eval_hit) mem.wr_en = 1'b0; // RULE7
            else if (s.cal == CAL_RUN || s.recal) mem.wr_en = 1'b1; // RULE5 RULE12
            else if (above_by(eval_imp, mem.ra_data, s.evr)) mem.wr_en = 1'b0; // RULE8
            else mem.wr_en = eval_imp != mem.ra_data; // RULE9 RULE10
            if (s.ch == 4'(NCH - 1)) n.eng = ENG_WRAP;
            else
            begin
               n.ch = s.ch + 4'h1;
               n.eng = ENG_READ;
            end
         end
         ENG_WRAP:
         begin
            n.eng = ENG_IDLE;
            n.recal = 1'b0;
            // calibration sequencing, counted in sensor ticks
            case (s.cal)
               CAL_RUN:
                  if (s.sweep_touch)
                  begin
                     n.cal = CAL_HOLD; // RULE6
                     n.quiet = 16'h0000;
                  end
                  else if (s.cal_cnt == CAL_RUN_TICKS - 8'h01)
                  begin
                     n.cal = CAL_TRACK; // RULE5
                     n.quiet = 16'h0000;
                     n.ival_cnt = 8'h00;
                     ev[INT_CAL_BIT] = 1'b1;
                  end
                  else n.cal_cnt = s.cal_cnt + 8'h01;
               CAL_HOLD:
                  if (s.sweep_touch) n.quiet = 16'h0000;
                  else if (s.quiet + 16'h0001 >= 16'({s.cal_int, 1'b0}))
                  begin
                     n.cal = CAL_RUN; // RULE6
                     n.cal_cnt = 8'h00;
                  end
                  else n.quiet = s.quiet + 16'h0001;
               CAL_TRACK:
                  if (s.sweep_touch)
                  begin
                     n.quiet = 16'h0000; // RULE11
                     n.ival_cnt = 8'h00;
                  end
                  else if (s.quiet < 16'(s.etc_wait)) n.quiet = s.quiet + 16'h0001; // RULE11
                  else if (s.ival_cnt + 8'h01 >= s.cal_int)
                  begin
                     n.recal = 1'b1; // RULE12
                     n.ival_cnt = 8'h00;
                  end
                  else n.ival_cnt = s.ival_cnt + 8'h01;
               default: n.cal = CAL_RUN;
            endcase
            // integration, strength threshold, optional second filter, selection
            last = s.integ_cnt >= s.integ;
            n.integ_cnt = last ? 8'h00 : s.integ_cnt + 8'h01;
            win_end = s.filt_win >= s.filt_per;
            for (int i = 0; i < NCH; i++)
            begin
               a_new[i] = (&s.acc[i]) ? s.acc[i] : s.acc[i] + 8'(s.inst[i]); // RULE13
               n.acc[i] = last ? 8'h00 : a_new[i];
               vt[i] = a_new[i] > s.thr[i]; // RULE14
               if (last)
               begin
                  n.strength[i] = a_new[i];
                  if (!s.feature[FEAT_FILTER_BIT]) n.filtered[i] = vt[i];
                  else if (win_end)
                  begin
                     n.filtered[i] = (s.filt_cnt[i] + 8'(vt[i])) > s.filt_thr; // RULE15
                     n.filt_cnt[i] = 8'h00;
                  end
                  else n.filt_cnt[i] = s.filt_cnt[i] + 8'(vt[i]);
               end
            end
            if (last)
            begin
               if (s.feature[FEAT_FILTER_BIT]) n.filt_win = win_end ? 8'h00 : s.filt_win + 8'h01;
               sel = pick(s.feature[FEAT_MODE_LSB +: 2], n.filtered, n.strength); // RULE19
               n.result = {4'h0, sel}; // RULE26
               ev[INT_TOUCH_BIT] = (|sel) && (sel != s.result[NCH-1:0]);
            end
         end
         default: n.eng = ENG_IDLE;
      endcase

      // status: an event in the clearing cycle survives
      n.pend = (s.pend & ~{2{clr}}) | ev; // RULE21 RULE25

      // address phase; reads see this cycle's write
      accept = HSEL && HTRANS[1] && HREADY;
      aidx = HADDR[9:2];
      rd_touch = accept && !HWRITE && (aidx == IDX_TOUCH_L || aidx == IDX_TOUCH_H);
      mem.rb_addr = 4'(aidx - IDX_CAL_IMP0);
      n.dp_active = accept;
      n.dp_write = HWRITE;
      n.dp_idx = aidx;
      n.rd_mem = accept && !HWRITE && in_bank(aidx, IDX_CAL_IMP0);
      if (accept && !HWRITE) n.rdata = {24'h000000, read_reg(n, aidx)};
      n.tint = (s.tint && !rd_touch) || ev[INT_TOUCH_BIT]; // RULE22

      // beep: duration in fine or coarse units, tone half period in tone units
      fine_end = s.fine_cnt == 15'(FINE_TICK_CYCLES - 1);
      unit_end = fine_end && (!s.beep_coarse || s.coarse_cnt == 8'(COARSE_PER_FINE - 1));
      if (beep_start)
      begin
         n.beeping = 1'b1; // RULE20
         n.beep_coarse = wv[7];
         n.dur_left = wv[6:0];
         n.fine_cnt = 15'h0000;
         n.coarse_cnt = 8'h00;
      end
      else if (s.beeping)
      begin
         n.fine_cnt = fine_end ? 15'h0000 : s.fine_cnt + 15'h0001;
         if (fine_end) n.coarse_cnt = unit_end ? 8'h00 : s.coarse_cnt + 8'h01;
         if (unit_end)
         begin
            n.dur_left = s.dur_left - 7'h01;
            if (s.dur_left == 7'h01) n.beeping = 1'b0;
         end
      end
      n.tone_pre = (s.tone_pre == 8'(TONE_UNIT_CYC - 1)) ? 8'h00 : s.tone_pre + 8'h01;
      if (s.tone_pre == 8'(TONE_UNIT_CYC - 1))
      begin
         n.tone_div = (s.tone_div == s.beep_freq) ? 8'h00 : s.tone_div + 8'h01;
         if (s.tone_div == s.beep_freq) n.beep_out = ~s.beep_out; // RULE20
      end
      if (!n.beeping)
      begin
         n.beep_out = 1'b0;
         n.tone_pre = 8'h00;
         n.tone_div = 8'h00;
      end
   end

   // state register
   always_ff @(posedge CLK or negedge RESETN)
   begin
      if (!RESETN)
      begin
         s <= '0;
         s.feature <= RST_FEATURE;
         s.tvr <= {NCH{RST_TVR}};
         s.evr <= RST_EVR;
         s.etc_wait <= RST_ETC_WAIT;
         s.thr <= {NCH{RST_STR_THR}};
         s.integ <= RST_INTEG;
         s.cal_int <= RST_CAL_INT;
         s.eng <= ENG_IDLE;
         s.cal <= CAL_RUN;
      end
      else
      begin
         s <= n;
      end
   end

   // bus is zero-wait; store words are muxed in from the store's register
   assign HREADYOUT = 1'b1;
   assign HRESP = 1'b0;
   assign HRDATA = s.rd_mem ? {24'h000000, mem.rb_data} : s.rdata;
   assign GENERAL_IRQ = |(s.pend & ~s.int_mask[1:0]); // RULE24
   assign TOUCH_IRQ = s.tint;
   assign BEEP_OUT = s.beep_out;
   assign REF_DELAY_CODE = s.ref_delay; // RULE23

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RESETN);

   sequence touch_read_s;
      rd_touch ##0 !ev[INT_TOUCH_BIT];
   endsequence
   sequence clr_write_s;
      s.dp_active && s.dp_write && s.dp_idx == IDX_INT_CLR && ev == 2'h0;
   endsequence
   sequence eval_s;
      s.eng == ENG_EVAL && s.valid[s.ch];
   endsequence

   chk_touch_keeps_ref: assert property (eval_s ##0 eval_hit |-> !mem.wr_en) // RULE7
      else $error("reference written on a touch");
   chk_below_loads: assert property (eval_s ##0 eval_imp < mem.ra_data |-> mem.wr_en && mem.wr_data == eval_imp) // RULE10
      else $error("reference not replaced by lower measurement");
   chk_env_band_keeps: assert property (eval_s ##0 (s.cal == CAL_TRACK && !s.recal && !eval_hit
      && above_by(eval_imp, mem.ra_data, s.evr)) |-> !mem.wr_en) // RULE8
      else $error("reference moved inside the environment band");
   chk_env_tracks: assert property (eval_s ##0 (eval_imp > mem.ra_data && !above_by(eval_imp, mem.ra_data, s.evr))
      |-> mem.wr_en ##1 s.eng == ENG_READ || s.eng == ENG_WRAP) // RULE9
      else $error("reference did not follow a small rise");
   chk_tint_read_clear: assert property (touch_read_s |=> !TOUCH_IRQ) // RULE22
      else $error("touch interrupt survived a result read");
   chk_tint_set: assert property (ev[INT_TOUCH_BIT] |=> TOUCH_IRQ // RULE22
      && GENERAL_IRQ == (!s.int_mask[INT_TOUCH_BIT] || (s.pend[INT_CAL_BIT] && !s.int_mask[INT_CAL_BIT])))
      else $error("touch event not flagged");
   chk_gint_clear: assert property (clr_write_s |=> !GENERAL_IRQ) // RULE25
      else $error("general interrupt survived a clear");
   chk_gint_holds: assert property (GENERAL_IRQ && !(s.dp_active && s.dp_write) |=> GENERAL_IRQ) // RULE21
      else $error("general interrupt dropped without a clear");
   chk_mode_one: assert property ($changed(s.result) && s.feature[2:1] == 2'h1 |-> $onehot0(s.result)) // RULE16
      else $error("mode one passed more than one key");
   chk_mode_three: assert property ($changed(s.result) && s.feature[2:1] == 2'h3 |-> $countones(s.result) <= 2) // RULE18
      else $error("mode three passed more than two keys");
   chk_run_length: assert property (s.cal == CAL_RUN ##1 s.cal == CAL_TRACK |-> $past(s.cal_cnt) == 8'h95) // RULE5
      else $error("initial calibration ended early");
endmodule : touch_key_detect_filter
`default_nettype wire

// ==== hdl/touch_key_pkg.sv ====
// constants, register indexes, reset values and state encodings for the touch-key engine
// assumes a 200 MHz system clock and byte-wide registers, each held in one 32-bit bus word
`default_nettype none
package touch_key_pkg;
   localparam int NCH = 12;
   localparam int CLK_PERIOD_PS = 5000;
   // register indexes; the bus byte address is four times the index
   localparam logic [7:0] IDX_FEATURE = 8'h00;
   localparam logic [7:0] IDX_TVR0 = 8'h01;
   localparam logic [7:0] IDX_EVR = 8'h0D;
   localparam logic [7:0] IDX_ETC_WAIT = 8'h0E;
   localparam logic [7:0] IDX_REF_DELAY = 8'h0F;
   localparam logic [7:0] IDX_STR_THR0 = 8'h10;
   localparam logic [7:0] IDX_INTEG = 8'h1C;
   localparam logic [7:0] IDX_INT_MASK = 8'h26;
   localparam logic [7:0] IDX_INT_CLR = 8'h27;
   localparam logic [7:0] IDX_BEEP_PER = 8'h28;
   localparam logic [7:0] IDX_BEEP_FREQ = 8'h29;
   localparam logic [7:0] IDX_CAL_INT = 8'h2A;
   localparam logic [7:0] IDX_FILT_PER = 8'h2D;
   localparam logic [7:0] IDX_FILT_THR = 8'h2E;
   localparam logic [7:0] IDX_STRENGTH0 = 8'h50;
   localparam logic [7:0] IDX_CAL_IMP0 = 8'h5C;
   localparam logic [7:0] IDX_IMP0 = 8'h68;
   localparam logic [7:0] IDX_STA = 8'h74;
   localparam logic [7:0] IDX_TOUCH_L = 8'h75;
   localparam logic [7:0] IDX_TOUCH_H = 8'h76;
   localparam logic [7:0] IDX_INT_PEND = 8'h77;
   // values after reset
   localparam logic [7:0] RST_FEATURE = 8'h04;
   localparam logic [7:0] RST_TVR = 8'h08;
   localparam logic [7:0] RST_EVR = 8'h04;
   localparam logic [7:0] RST_ETC_WAIT = 8'h27;
   localparam logic [7:0] RST_STR_THR = 8'h01;
   localparam logic [7:0] RST_INTEG = 8'h0F;
   localparam logic [7:0] RST_CAL_INT = 8'h30;
   // field positions
   localparam int FEAT_FILTER_BIT = 0;
   localparam int FEAT_MODE_LSB = 1;
   localparam int INT_TOUCH_BIT = 0;
   localparam int INT_CAL_BIT = 1;
   // timing, in sensor ticks and in system clock cycles
   localparam logic [7:0] CAL_RUN_TICKS = 8'h96;
   localparam int TONE_UNIT_NS = 1250;
   localparam int TONE_UNIT_CYC = (TONE_UNIT_NS * 1000) / CLK_PERIOD_PS;
   localparam int BEEP_FINE_US = 100;
   localparam int BEEP_FINE_CYC = (BEEP_FINE_US * 1000000) / CLK_PERIOD_PS;
   localparam int BEEP_COARSE_US = 20000;
   localparam int COARSE_PER_FINE = BEEP_COARSE_US / BEEP_FINE_US;
   typedef enum logic [1:0] {ENG_IDLE = 2'h0, ENG_READ = 2'h1, ENG_EVAL = 2'h3, ENG_WRAP = 2'h2} eng_type;
   typedef enum logic [1:0] {CAL_RUN = 2'h0, CAL_TRACK = 2'h1, CAL_HOLD = 2'h3} cal_type;
endpackage : touch_key_pkg
`default_nettype wire

// ==== hdl/ref_store_if.sv ====
// carrier between the touch engine and its reference store
// one write port and two registered read ports, all on the system clock
`default_nettype none
interface ref_store_if;
   logic wr_en;
   logic [3:0] wr_addr;
   logic [7:0] wr_data;
   logic [3:0] ra_addr;
   logic [7:0] ra_data;
   logic [3:0] rb_addr;
   logic [7:0] rb_data;
   modport owner (output wr_en, wr_addr, wr_data, ra_addr, rb_addr, input ra_data, rb_data);
   modport store (input wr_en, wr_addr, wr_data, ra_addr, rb_addr, output ra_data, rb_data);
endinterface : ref_store_if
`default_nettype wire

// ==== hdl/ref_store.sv ====
// sixteen-word store holding each channel's calibrated reference impedance
// assumes the owner tracks which words are valid; the array itself has no reset
`default_nettype none
module ref_store
(
   input wire logic CLK,
   ref_store_if.store port
);
   logic [7:0] mem [16];
   logic [7:0] ra_q;
   logic [7:0] rb_q;

   // write and both reads on the same edge, read data registered
   always_ff @(posedge CLK)
   begin
      if (port.wr_en)
      begin
         mem[port.wr_addr] <= port.wr_data;
      end
      ra_q <= mem[port.ra_addr];
      rb_q <= mem[port.rb_addr];
   end

   assign port.ra_data = ra_q;
   assign port.rb_data = rb_q;
endmodule : ref_store
`default_nettype wire

// ==== test/sensor_model.sv ====
// pad-side stand-in: free-running sensor clock and per-channel impedance
// assumes the bench sets the wanted impedances on the system clock
`default_nettype none
module sensor_model
   import touch_key_pkg::*;
#(
   parameter int HALF = 24
)
(
   input wire logic clk,
   input wire logic [NCH*8-1:0] imp_set,
   output logic sclk,
   output logic [NCH*8-1:0] meas
);
   timeunit 1ns;
   timeprecision 1ps;
   initial sclk = 1'b0;
   // tick spacing well above the 26-cycle sweep
   always @(posedge clk)
   begin
      repeat (HALF - 1) @(posedge clk);
      sclk <= ~sclk;
   end
   // impedance moves only while the sensor clock is low, never at a tick
   always @(posedge clk)
      if (!sclk)
         meas <= imp_set;
endmodule : sensor_model
`default_nettype wire

// ==== test/touch_key_detect_filter_test.sv ====
// self-checking bench: bus master, register rows, calibration, touch and tracking cases
// assumes zero-wait-state slave answers and the sensor model on the pad side
`default_nettype none
module touch_key_detect_filter_test
   import touch_key_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int PER = 48;
   typedef struct {logic w; logic [7:0] idx; logic [7:0] wd; logic [7:0] exp;} row_type;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [NCH-1:0][7:0] imp = {NCH{8'h40}};
   wire logic hready, hresp, sclk, gen_irq, touch_irq, beep;
   wire logic [31:0] hrdata;
   wire logic [7:0] delay_code;
   wire logic [NCH*8-1:0] meas;
   logic [31:0] rd;
   logic [7:0] lo;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   // variances stay at 8 and 4, inside the advised bands
   row_type rows [10] = '{'{1'b0, IDX_FEATURE, 8'h00, RST_FEATURE}, '{1'b0, IDX_TVR0 + 8'h0B, 8'h00, RST_TVR},
      '{1'b0, IDX_EVR, 8'h00, RST_EVR}, '{1'b0, IDX_ETC_WAIT, 8'h00, RST_ETC_WAIT},
      '{1'b0, IDX_STR_THR0, 8'h00, RST_STR_THR}, '{1'b0, IDX_INTEG, 8'h00, RST_INTEG},
      '{1'b0, IDX_CAL_INT, 8'h00, RST_CAL_INT}, '{1'b1, IDX_REF_DELAY, 8'h5A, 8'h5A},
      '{1'b1, IDX_STRENGTH0, 8'h33, 8'h00}, '{1'b1, 8'h40, 8'hA5, 8'h00}};
   always #2.5 clk = ~clk;
   always @(posedge clk) cyc++;
   touch_key_detect_filter #(.FINE_TICK_CYCLES(20)) touch_key_detect_filter_i (.CLK(clk), .RESETN(resetn),
      .HSEL(1'b1), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp), .SENSOR_CLK(sclk), .MEAS_IMP(meas),
      .REF_DELAY_CODE(delay_code), .GENERAL_IRQ(gen_irq), .TOUCH_IRQ(touch_irq), .BEEP_OUT(beep));
   sensor_model #(.HALF(PER / 2)) sensor_model_i (.clk(clk), .imp_set(imp), .sclk(sclk), .meas(meas));
   // one single transfer; the slave's own ready paces both phases
   task automatic xfer(input logic w, input logic [7:0] idx, input logic [7:0] wd);
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge clk); while (hready !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, wd};
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
   endtask : xfer
   task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp);
      xfer(1'b0, idx, 8'h00);
      compares++;
      if (rd !== {24'h0, exp})
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, rd, exp);
      end
   endtask : rdchk
   task automatic pinchk(input logic got, input logic exp);
      compares++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask : pinchk
   task automatic test_done;
      if (mismatches == 0 && compares > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : test_done
   initial
   begin
      repeat (4) @(posedge clk);
      resetn <= 1'b1;
      // reset values, read-back, read-only and unmapped places
      foreach (rows[i])
      begin
         if (rows[i].w)
            xfer(1'b1, rows[i].idx, rows[i].wd);
         rdchk(rows[i].idx, rows[i].exp);
      end
      pinchk(delay_code == 8'h5A && hresp === 1'b0, 1'b1);
      rdchk(IDX_STA, 8'h00);
      xfer(1'b1, IDX_INTEG, 8'h03);
      xfer(1'b1, IDX_INT_MASK, 8'h01);
      rd = 32'h0;
      while (rd[1:0] !== 2'h1 && cyc < 200 * PER)
         xfer(1'b0, IDX_STA, 8'h00);
      pinchk(cyc > 149 * PER && cyc < 153 * PER, 1'b1);
      pinchk(gen_irq, 1'b1);
      rdchk(IDX_INT_PEND, 8'h02);
      xfer(1'b1, IDX_INT_CLR, 8'h01);
      rdchk(IDX_INT_PEND, 8'h00);
      pinchk(gen_irq, 1'b0);
      // two keys pressed, touch source masked off the general line
      imp[3] <= 8'h50;
      imp[9] <= 8'h50;
      repeat (8 * PER) @(posedge clk);
      pinchk(touch_irq, 1'b1);
      pinchk(gen_irq, 1'b0);
      rdchk(IDX_STRENGTH0 + 8'h03, 8'h04);
      rdchk(IDX_CAL_IMP0 + 8'h03, 8'h40);
      rdchk(IDX_TOUCH_H, 8'h02);
      rdchk(IDX_TOUCH_L, 8'h08);
      pinchk(touch_irq, 1'b0);
      // mode one keeps one of the two equal keys, mode three with the filter on keeps both
      xfer(1'b1, IDX_FEATURE, 8'h02);
      repeat (5 * PER) @(posedge clk);
      xfer(1'b0, IDX_TOUCH_L, 8'h00);
      lo = rd[7:0];
      xfer(1'b0, IDX_TOUCH_H, 8'h00);
      pinchk($countones({rd[3:0], lo}) == 1, 1'b1);
      xfer(1'b1, IDX_FEATURE, 8'h07);
      repeat (5 * PER) @(posedge clk);
      rdchk(IDX_TOUCH_L, 8'h08);
      rdchk(IDX_TOUCH_H, 8'h02);
      // release; drift down, small rise, mid-band rise
      imp <= {{9{8'h40}}, 8'h46, 8'h42, 8'h30};
      repeat (4 * PER) @(posedge clk);
      rdchk(IDX_CAL_IMP0, 8'h30);
      rdchk(IDX_CAL_IMP0 + 8'h01, 8'h42);
      rdchk(IDX_CAL_IMP0 + 8'h02, 8'h40);
      // short beep at the top tone: high after one tone unit, silent after 32 fine units
      xfer(1'b1, IDX_BEEP_FREQ, 8'h00);
      xfer(1'b1, IDX_BEEP_PER, 8'h20);
      rdchk(IDX_STA, 8'h05);
      repeat (300) @(posedge clk);
      pinchk(beep, 1'b1);
      repeat (400) @(posedge clk);
      pinchk(beep, 1'b0);
      rdchk(IDX_STA, 8'h01);
      // reset in mid-run: registers back to reset values, calibration restarts
      resetn <= 1'b0;
      @(posedge clk);
      resetn <= 1'b1;
      pinchk(delay_code == 8'h00, 1'b1);
      rdchk(IDX_STA, 8'h00);
      test_done;
   end
   // hang guard, about twice the expected run
   initial
   begin
      repeat (20000) @(posedge clk);
      mismatches++;
      test_done;
   end
endmodule : touch_key_detect_filter_test
`default_nettype wire
